// File: common/pdfs_consts.svh
// Offsets, field positions, reset values and timing for the port D pin mux
`ifndef PDFS_CONSTS_SVH
`define PDFS_CONSTS_SVH

// Word index of each register on the bus (byte address is four times this)
`define PDFS_IDX_DIR        2'h0
`define PDFS_IDX_UPPER      2'h1
`define PDFS_IDX_LOWER      2'h2
`define PDFS_IDX_PINS       2'h3

// Reset values
`define PDFS_DIR_RESET      14'h0000
`define PDFS_UPPER_RESET    16'h0000
`define PDFS_LOWER_RESET    16'h0000

// Upper select register fields
`define PDFS_TOP_FUNC_HI    11
`define PDFS_TOP_FUNC_LO    10
`define PDFS_UPPER_RW_MASK  16'h0d55
`define PDFS_UPPER_RSVD     16'hf2aa

// Lower select register: odd bits are reserved
`define PDFS_LOWER_RW_MASK  16'h5555

// Top pin function codes
`define PDFS_TOP_GPIO       2'h0
`define PDFS_TOP_PULSE      2'h1
`define PDFS_TOP_CAN        2'h2

// Wait states before the slave answers
`define PDFS_WAIT_CYCLES    1

`endif

// File: common/pdfs_pkg.sv
// Types shared by the port D pin mux
package pdfs_pkg;

    // Pin function, one-hot
    typedef enum logic [2:0] {
        PDFS_FUNC_GPIO   = 3'b001,
        PDFS_FUNC_TIMER  = 3'b010,
        PDFS_FUNC_PERIPH = 3'b100
    } pdfs_func_type;

    // Drive toward one pad
    typedef struct packed {
        logic out;
        logic oe;
    } pdfs_pad_type;

    // Signals offered by the on-chip peripherals
    typedef struct packed {
        logic [7:0] timer_out;
        logic [4:0] pulse_lo;
        logic       pulse_6;
        logic       can_tx;
    } pdfs_periph_type;

endpackage

// File: rtl/pdfs_pin_cell.sv
// One pad driver: picks data and enable from the selected function
`timescale 1ns/10ps
module pdfs_pin_cell (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire pdfs_pkg::pdfs_func_type func,
    input  wire logic                   dir_bit,
    input  wire logic                   gpio_data,
    input  wire logic                   periph_data,
    output      pdfs_pkg::pdfs_pad_type pad
);
    import pdfs_pkg::*;

    pdfs_pad_type pad_reg;
    pdfs_pad_type pad_next;

    // Function-dependent source
    always_comb begin
        pad_next = '0;
        case (func)
            // direction gates gpio and timer only
            PDFS_FUNC_GPIO: begin
                pad_next.out = gpio_data;
                pad_next.oe  = dir_bit;
            end
            PDFS_FUNC_TIMER: begin
                pad_next.out = periph_data;
                pad_next.oe  = dir_bit;
            end
            PDFS_FUNC_PERIPH: begin
                pad_next.out = periph_data;
                pad_next.oe  = 1'b1;
            end
            default: begin
                pad_next = '0;
            end
        endcase
    end

    // Pad flops, released on reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pad_reg <= '0;
        end else begin
            pad_reg <= pad_next;
        end
    end

    assign pad = pad_reg;

    property p_dir_enable;
        @(posedge core_clk) disable iff (reset)
        (func != PDFS_FUNC_PERIPH) |=> (pad.oe == $past(dir_bit));
    endproperty
    a_dir_enable: assert property (p_dir_enable)
        else $error("pad enable does not follow direction bit");

    property p_periph_drive;
        @(posedge core_clk) disable iff (reset)
        (func == PDFS_FUNC_PERIPH) |=>
            (pad.oe && pad.out == $past(periph_data));
    endproperty
    a_periph_drive: assert property (p_periph_drive)
        else $error("peripheral function not driving its pad");

endmodule // pdfs_pin_cell

// File: rtl/pdfs_top.sv
// Port D direction and function select with Avalon-MM register slave
//
// Notes on behaviour
// - A 14-bit direction register holds one bit per pin for pins 13..0.
// - Direction only matters for pins in general I/O or timer function.
// - Direction bit 1 makes an enabled pin an output, 0 an input.
// - Direction clears on power-on reset and hardware standby, not watchdog.
// - Direction keeps its value through software standby and sleep.
// - Upper select covers pins 13..8, lower select covers pins 7..0.
// - Both selects clear on power-on reset and hardware standby, not watchdog.
// - Both selects keep their values through software standby and sleep.
// - Upper select bits 15..12, 9, 7, 5, 3, 1 read zero; software writes 0.
// - Bits 11:10 pick pin 13: 00 I/O, 01 pulse 6, 10 CAN, 11 not allowed.
// - Bit 8 picks pin 12: 0 general I/O, 1 pulse output 4.
// - Bit 6 picks pin 11: 0 general I/O, 1 pulse output 3.
// - Bit 4 picks pin 10: 0 general I/O, 1 pulse output 2.
// - Bit 2 picks pin 9: 0 general I/O, 1 pulse output 1.
// - Bit 0 picks pin 8: 0 general I/O, 1 pulse output 0.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`include "pdfs_consts.svh"
module pdfs_top #(
    parameter int PIN_COUNT = 14
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic                    wdt_reset,
    input  wire logic                    hw_standby,
    input  wire logic [1:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    input  wire logic [3:0]              byteenable,
    output      logic [31:0]             readdata,
    output      logic                    waitrequest,
    input  wire logic [13:0]             gpio_data,
    input  wire pdfs_pkg::pdfs_periph_type periph,
    input  wire logic [13:0]             pin_in,
    output      logic [13:0]             pin_out,
    output      logic [13:0]             pin_oe,
    output      logic [7:0]              timer_in
);
    import pdfs_pkg::*;

    // Layout is fixed by the register map
    if (PIN_COUNT != 14) begin : g_bad_count
        $error("pdfs_top serves exactly 14 pins");
    end

    // Maps one select bit to its function
    function automatic pdfs_func_type sel_func(input logic sel,
                                               input pdfs_func_type alt);
        sel_func = sel ? alt : PDFS_FUNC_GPIO;
    endfunction

    logic [13:0] dir_reg;
    logic [15:0] upper_reg;
    logic [15:0] lower_reg;
    logic        ack_reg;
    logic [31:0] readdata_reg;
    logic [13:0] dir_next;
    logic [15:0] upper_next;
    logic [15:0] lower_next;
    logic [31:0] readdata_next;

    wire         req_w       = read | write;
    wire         take_w      = write & ack_reg;
    wire         clear_w     = reset | hw_standby;
    wire  [15:0] lane_mask_w = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    wire  [15:0] wdata_w     = writedata[15:0];
    wire  [1:0]  top_sel_w   = upper_reg[`PDFS_TOP_FUNC_HI:`PDFS_TOP_FUNC_LO];

    // Bus answer: one wait state, then done
    assign waitrequest = req_w & ~ack_reg;
    assign readdata    = readdata_reg;

    // Byte-lane merge of each register
    assign dir_next   = (dir_reg & ~lane_mask_w[13:0])
                      | (wdata_w[13:0] & lane_mask_w[13:0]);
    assign upper_next = ((upper_reg & ~lane_mask_w)
                      | (wdata_w & lane_mask_w)) & `PDFS_UPPER_RW_MASK;
    assign lower_next = ((lower_reg & ~lane_mask_w)
                      | (wdata_w & lane_mask_w)) & `PDFS_LOWER_RW_MASK;

    // Read mux; unmapped space reads zero
    always_comb begin
        readdata_next = 32'h0000_0000;
        case (address)
            // top two direction bits read zero
            `PDFS_IDX_DIR:   readdata_next = {18'h00000, dir_reg};
            `PDFS_IDX_UPPER: readdata_next = {16'h0000, upper_reg};
            `PDFS_IDX_LOWER: readdata_next = {16'h0000, lower_reg};
            `PDFS_IDX_PINS:  readdata_next = {18'h00000, pin_in};
            default:         readdata_next = 32'h0000_0000;
        endcase
    end

    // Handshake; watchdog reset only drops the bus answer
    always_ff @(posedge core_clk) begin
        if (reset || wdt_reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_w & ~ack_reg;
        end
    end

    // Read data captured ahead of the answering edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            readdata_reg <= 32'h0000_0000;
        end else if (read && !ack_reg) begin
            readdata_reg <= readdata_next;
        end
    end

    // clear on power-on or standby only
    always_ff @(posedge core_clk) begin
        if (clear_w) begin
            dir_reg <= `PDFS_DIR_RESET;
        end else if (take_w && address == `PDFS_IDX_DIR) begin
            dir_reg <= dir_next; // byte-lane write
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear_w) begin
            upper_reg <= `PDFS_UPPER_RESET;
            lower_reg <= `PDFS_LOWER_RESET;
        end else if (take_w && address == `PDFS_IDX_UPPER) begin
            upper_reg <= upper_next;
        end else if (take_w && address == `PDFS_IDX_LOWER) begin
            lower_reg <= lower_next;
        end
    end

    // Per-pin function and peripheral source
    pdfs_func_type func_w   [14];
    logic [13:0]   periph_w;
    pdfs_pad_type  pad_w    [14];

    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_lower
        assign func_w[gi]   = sel_func(lower_reg[2*gi], PDFS_FUNC_TIMER);
        assign periph_w[gi] = periph.timer_out[gi];
    end

    // pin 12 / pin 11 / pin 10 / pin 9 / pin 8
    for (gi = 8; gi < 13; gi++) begin : g_upper
        assign func_w[gi]   = sel_func(upper_reg[2*(gi-8)], PDFS_FUNC_PERIPH);
        assign periph_w[gi] = periph.pulse_lo[gi-8];
    end

    // top pin decode, 11 left as I/O
    assign func_w[13]   = (top_sel_w == `PDFS_TOP_PULSE ||
                           top_sel_w == `PDFS_TOP_CAN) ?
                          PDFS_FUNC_PERIPH : PDFS_FUNC_GPIO;
    assign periph_w[13] = (top_sel_w == `PDFS_TOP_CAN) ?
                          periph.can_tx : periph.pulse_6;

    // Pad drivers
    for (gi = 0; gi < 14; gi++) begin : g_pad
        pdfs_pin_cell u_cell (
            .core_clk    (core_clk),
            .reset       (reset),
            .func        (func_w[gi]),
            .dir_bit     (dir_reg[gi]),
            .gpio_data   (gpio_data[gi]),
            .periph_data (periph_w[gi]),
            .pad         (pad_w[gi])
        );
        assign pin_out[gi] = pad_w[gi].out;
        assign pin_oe[gi]  = pad_w[gi].oe;
    end

    // Timer capture inputs see the pads
    assign timer_in = pin_in[7:0];

    property p_dir_clear;
        @(posedge core_clk)
        reset |=> (dir_reg == `PDFS_DIR_RESET);
    endproperty
    a_dir_clear: assert property (p_dir_clear)
        else $error("direction not cleared by reset");

    property p_sel_clear;
        @(posedge core_clk)
        hw_standby |=> (upper_reg == 16'h0000 && lower_reg == 16'h0000);
    endproperty
    a_sel_clear: assert property (p_sel_clear)
        else $error("select registers not cleared in standby");

    property p_wdt_keep;
        @(posedge core_clk) disable iff (reset || hw_standby)
        (wdt_reset && !take_w) |=> $stable(dir_reg) && $stable(upper_reg);
    endproperty
    a_wdt_keep: assert property (p_wdt_keep)
        else $error("watchdog reset disturbed port registers");

    // full write lands on the next edge
    property p_dir_write;
        @(posedge core_clk) disable iff (reset || hw_standby)
        (take_w && address == `PDFS_IDX_DIR && byteenable[1:0] == 2'h3)
            |=> (dir_reg == $past(writedata[13:0]));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not stored");

    property p_upper_rsvd;
        @(posedge core_clk) disable iff (reset)
        (read && !waitrequest && address == `PDFS_IDX_UPPER)
            |-> ((readdata[15:0] & `PDFS_UPPER_RSVD) == 16'h0000);
    endproperty
    a_upper_rsvd: assert property (p_upper_rsvd)
        else $error("reserved upper select bits read non-zero");

    property p_dir_rsvd;
        @(posedge core_clk) disable iff (reset)
        (read && !waitrequest && address == `PDFS_IDX_DIR)
            |-> (readdata[31:14] == 18'h00000);
    endproperty
    a_dir_rsvd: assert property (p_dir_rsvd)
        else $error("direction bits 15 and 14 read non-zero");

    // CAN code routes transmit data to pin 13
    property p_can_route;
        @(posedge core_clk) disable iff (reset)
        (top_sel_w == `PDFS_TOP_CAN) |=>
            (pin_oe[13] && pin_out[13] == $past(periph.can_tx));
    endproperty
    a_can_route: assert property (p_can_route)
        else $error("pin 13 not carrying CAN transmit data");

    // pulse 4 reaches pin 12 one edge after the select write lands
    property p_pin12_pulse;
        @(posedge core_clk) disable iff (reset || hw_standby)
        (upper_reg[8] && $stable(upper_reg)) |=>
            (pin_out[12] == $past(periph.pulse_lo[4]));
    endproperty
    a_pin12_pulse: assert property (p_pin12_pulse)
        else $error("pin 12 not carrying pulse output 4");

    // Bus answer within one wait state
    property p_answer_bound;
        @(posedge core_clk) disable iff (reset || wdt_reset)
        $rose(req_w) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_answer_bound: assert property (p_answer_bound)
        else $error("bus answer not given after one wait state");

endmodule // pdfs_top

// File: tb/pdfs_periph_model.sv
// Far-side model: timer, pulse and CAN signals plus pad levels
`timescale 1ns/10ps
module pdfs_periph_model (
    input  wire logic              core_clk,
    output pdfs_pkg::pdfs_periph_type periph,
    output logic [13:0]            pin_in
);
    import pdfs_pkg::*;
    logic [15:0] lfsr_reg = 16'hace1;
    // Every source shifts each cycle, so a stale value passes only where a bit repeats
    always_ff @(posedge core_clk) begin
        lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13]
                     ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
    // Struct packing and pad levels
    assign periph = pdfs_periph_type'(lfsr_reg[14:0]);
    assign pin_in = lfsr_reg[15:2] ^ 14'h2a5a;
endmodule // pdfs_periph_model

// File: tb/pdfs_top_bench.sv
// Self-checking bench for the port D pin mux
`timescale 1ns/10ps
`include "pdfs_consts.svh"
module pdfs_top_bench;
    import pdfs_pkg::*;
    logic            core_clk, reset, wdt_reset, hw_standby, read, write;
    logic [1:0]      address;
    logic [31:0]     writedata, readdata, q, r1, r2;
    logic [3:0]      byteenable;
    logic            waitrequest, chk_on;
    logic [13:0]     gpio_data, pin_in, pin_out, pin_oe;
    logic [7:0]      timer_in;
    pdfs_periph_type periph;
    logic [15:0]     dir_s, up_s, lo_s;
    logic [27:0]     exp_pad;
    int              err_count, n_tests, cyc, seed;

    pdfs_top u_dut (.core_clk(core_clk), .reset(reset),
        .wdt_reset(wdt_reset), .hw_standby(hw_standby), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .gpio_data(gpio_data), .periph(periph),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .timer_in(timer_in));
    pdfs_periph_model u_far (.core_clk(core_clk), .periph(periph),
        .pin_in(pin_in));

    // Expected pad drive per pin from the select fields
    function automatic logic [27:0] pad_exp(input logic [15:0] d, u, l,
        input logic [13:0] g, input pdfs_periph_type p);
        logic [13:0] o;
        logic [13:0] e;
        o = g;
        e = d[13:0];
        for (int n = 0; n < 8; n++) if (l[2*n]) o[n] = p.timer_out[n];
        for (int n = 8; n < 13; n++) if (u[2*(n-8)]) begin
            o[n] = p.pulse_lo[n-8];
            e[n] = 1'b1;
        end
        if (u[11:10] == `PDFS_TOP_PULSE) begin
            o[13] = p.pulse_6;
            e[13] = 1'b1;
        end
        if (u[11:10] == `PDFS_TOP_CAN) begin
            o[13] = p.can_tx;
            e[13] = 1'b1;
        end
        return {o, e};
    endfunction

    // Lane merge with writable mask
    function automatic logic [15:0] merge(input logic [15:0] old, d,
        input logic [3:0] be, input logic [15:0] msk);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return ((old & ~m) | (d & m)) & msk;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [1:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        // Only the bench timeout ends a hung wait
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        // Shadows move on the edge at which the write lands
        if (w && a == `PDFS_IDX_DIR)
            dir_s <= merge(dir_s, d, be, 16'h3fff);
        if (w && a == `PDFS_IDX_UPPER)
            up_s <= merge(up_s, d, be, `PDFS_UPPER_RW_MASK);
        if (w && a == `PDFS_IDX_LOWER)
            lo_s <= merge(lo_s, d, be, `PDFS_LOWER_RW_MASK);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_all;
        bus(0, `PDFS_IDX_DIR, 0, 4'hf);
        check("direction", q, {16'h0, dir_s});
        bus(0, `PDFS_IDX_UPPER, 0, 4'hf);
        check("upper_select", q, {16'h0, up_s});
        bus(0, `PDFS_IDX_LOWER, 0, 4'hf);
        check("lower_select", q, {16'h0, lo_s});
    endtask

    // Shadows clear on the edge at which the design first sees the clear
    task automatic clr_all;
        @(posedge core_clk);
        dir_s <= '0;
        up_s <= '0;
        lo_s <= '0;
    endtask

    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Pad comparison every cycle against the shadows of the last cycle
    always @(posedge core_clk) begin
        cyc++;
        if (cyc >= 6000) begin
            err_count++;
            wrap_up;
        end else begin
            exp_pad <= pad_exp(dir_s, up_s, lo_s, gpio_data, periph);
            gpio_data <= $random(seed);
            #1;
            if (chk_on === 1'b1) begin
                check("pin_out", pin_out, exp_pad[27:14]);
                check("pin_oe", pin_oe, exp_pad[13:0]);
                check("timer_in", timer_in, pin_in[7:0]);
            end
        end
    end

    initial begin
        seed = 51;
        {reset, wdt_reset, hw_standby, read, write, chk_on} = 6'h20;
        {address, writedata, byteenable} = 0;
        {dir_s, up_s, lo_s, err_count, n_tests, cyc} = 0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_on = 1'b1;
        rd_all;
        $display("test reset values done");
        bus(1, `PDFS_IDX_DIR, 32'hffff_ffff, 4'h3);
        bus(1, `PDFS_IDX_UPPER, 32'h0000_0955, 4'h3);
        rd_all;
        for (int c = 0; c < 4; c++) begin
            bus(1, `PDFS_IDX_UPPER, {20'h0, 2'(c % 3), 10'h155}, 4'h3);
            bus(1, `PDFS_IDX_DIR, $random(seed), 4'h3);
            repeat (4) @(posedge core_clk);
        end
        bus(1, `PDFS_IDX_UPPER, 32'h0, 4'h3);
        bus(1, `PDFS_IDX_LOWER, 32'hffff, 4'h3);
        repeat (4) @(posedge core_clk);
        bus(1, `PDFS_IDX_DIR, 32'h0, 4'h0);
        bus(1, `PDFS_IDX_DIR, 32'h0, 4'h1);
        bus(1, `PDFS_IDX_PINS, 32'hffff, 4'hf);
        bus(0, `PDFS_IDX_PINS, 0, 4'hf);
        check("pin_level_top", q >> 14, 32'h0);
        rd_all;
        $display("test fields and lanes done");
        @(posedge core_clk);
        wdt_reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        wdt_reset <= 1'b0;
        rd_all;
        @(posedge core_clk);
        hw_standby <= 1'b1;
        clr_all;
        repeat (3) @(posedge core_clk);
        hw_standby <= 1'b0;
        rd_all;
        $display("test watchdog and standby done");
        for (int i = 0; i < 40; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            if (r1[1:0] == `PDFS_IDX_UPPER) r2 = r2 & `PDFS_UPPER_RW_MASK;
            // Reserved top pin code is never written
            if (r1[1:0] == `PDFS_IDX_UPPER && r2[11:10] == 2'h3) r2[10] = 1'b0;
            bus(1, r1[1:0], r2, r1[7:4]);
            if (i % 8 == 7) rd_all;
        end
        $display("test random traffic done");
        chk_on = 1'b0;
        @(posedge core_clk);
        reset <= 1'b1;
        clr_all;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_on = 1'b1;
        rd_all;
        $display("test second reset done");
        wrap_up;
    end
endmodule // pdfs_top_bench
